// *** pkg/dmr_pkg.sv ***
// package: command encodings, mode register fields and timing constants
`default_nettype none
package dmr_pkg;
   // bank address of the multipurpose and extended settings registers
   localparam logic [2:0] BA_MULTI = 3'h3;
   localparam logic [2:0] BA_EXT = 3'h2;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   // field positions
   localparam int MP_EN_BIT = 2;
   localparam int MP_SEL_LO = 0;
   localparam int SRT_BIT = 7;
   // reset values
   localparam logic [1:0] MP_SEL_RST = 2'h0;
   // pattern byte returned while the pattern source is on (arbitrary choice)
   localparam logic [7:0] PATTERN_0 = 8'h55;
   localparam logic [7:0] PATTERN_1 = 8'h0f;
   localparam logic [7:0] PATTERN_2 = 8'hff;
   localparam logic [7:0] PATTERN_3 = 8'h00;
   // refresh intervals in ns, and cycles at the 20 MHz core clock
   localparam int CLK_PERIOD_NS = 50;
   localparam int REFI_NORMAL_NS = 7800;
   localparam int REFI_HOT_NS = 3900;
   localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS / CLK_PERIOD_NS;
   localparam int REFI_HOT_CYC = REFI_HOT_NS / CLK_PERIOD_NS;
   localparam int SELF_REF_CYC = REFI_NORMAL_CYC;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   // software register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_WDATA = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_RDATA = 4'h3;
   localparam logic [3:0] REG_RCOUNT = 4'h4;
   // command codes as {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_MODE = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_NOP = 3'h7;
endpackage
`default_nettype wire

// *** pkg/dmr_if.sv ***
// interface: command, address and read data between controller and dram
`default_nettype none
interface dmr_if;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [2:0] ba;
   logic [dmr_pkg::ADDR_W-1:0] addr;
   logic [dmr_pkg::DATA_W-1:0] dq;
   logic dq_valid;
   modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr, input dq, dq_valid);
   modport dram (input cs_n, ras_n, cas_n, we_n, ba, addr, output dq, dq_valid);
endinterface
`default_nettype wire

// *** rtl/dmr_dram.sv ***
// dram end: mode registers, pattern source and self-refresh rate
// Operation
// - controller writes multipurpose reg with bank three
// - reserved bits and BA2 written as zero
// - pattern source enabled returns fixed pattern
// - enable bit clear ignores select bits
// - hot case refreshes every 3.9 us
// - single rate 7.8 us interval option
// - self refresh temp bit in extended reg
// - temp bit set doubles self refresh rate
`default_nettype none
module dmr_dram (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   dmr_if.dram link,
   input wire logic self_ref_in,
   input wire logic [7:0] array_data_in,
   output logic mp_en_out,
   output logic srt_out,
   output logic self_ref_tick_out
);
   typedef struct packed {
      logic mp_en;
      logic [1:0] mp_sel;
      logic self_refresh_temp_select;
      logic [dmr_pkg::DATA_W-1:0] dq;
      logic dq_valid;
      logic [dmr_pkg::CNT_W-1:0] cnt;
      logic tick;
   } dmr_dst_t;
   dmr_dst_t st_r;
   dmr_dst_t st_nxt;
   logic [2:0] cmd;
   logic sel_cmd;
   logic [7:0] pat;
   logic [dmr_pkg::CNT_W-1:0] limit;
   ////////////////////////////////////////////////////////////////////
   // decode and next state
   always_comb begin
      cmd = {link.ras_n, link.cas_n, link.we_n};
      sel_cmd = !link.cs_n;
      st_nxt = st_r;
      st_nxt.dq_valid = 1'b0;
      st_nxt.tick = 1'b0;
      unique case (st_r.mp_sel)
         2'h0: pat = dmr_pkg::PATTERN_0;
         2'h1: pat = dmr_pkg::PATTERN_1;
         2'h2: pat = dmr_pkg::PATTERN_2;
         2'h3: pat = dmr_pkg::PATTERN_3;
      endcase
      // mode write decode; reserved bits simply not stored
      if (sel_cmd && cmd == dmr_pkg::CMD_MODE && link.ba == dmr_pkg::BA_MULTI) begin
         st_nxt.mp_en = link.addr[dmr_pkg::MP_EN_BIT];
         if (link.addr[dmr_pkg::MP_EN_BIT]) begin
            st_nxt.mp_sel = link.addr[dmr_pkg::MP_SEL_LO +: 2];
         end
      end
      if (sel_cmd && cmd == dmr_pkg::CMD_MODE && link.ba == dmr_pkg::BA_EXT) begin
         st_nxt.self_refresh_temp_select = link.addr[dmr_pkg::SRT_BIT];
      end
      if (sel_cmd && cmd == dmr_pkg::CMD_READ) begin
         st_nxt.dq_valid = 1'b1;
         st_nxt.dq = st_r.mp_en ? pat : array_data_in;
      end
      // doubled internal rate when set; single rate otherwise
      limit = st_r.self_refresh_temp_select ? dmr_pkg::CNT_W'(dmr_pkg::SELF_REF_CYC / 2)
                       : dmr_pkg::CNT_W'(dmr_pkg::SELF_REF_CYC);
      if (!self_ref_in) begin
         st_nxt.cnt = dmr_pkg::CNT_RST;
      end else if (st_r.cnt >= limit - 16'h0001) begin
         st_nxt.cnt = dmr_pkg::CNT_RST;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end
   // state register
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign link.dq = st_r.dq;
   assign link.dq_valid = st_r.dq_valid;
   assign mp_en_out = st_r.mp_en;
   assign srt_out = st_r.self_refresh_temp_select;
   assign self_ref_tick_out = st_r.tick;
endmodule
`default_nettype wire

// *** rtl/dmr_ctrl.sv ***
// controller end: mode writes, reads and refresh pacing by register port
`default_nettype none
module dmr_ctrl (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   dmr_if.ctrl link,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out
);
   typedef struct packed {
      logic cs_n;
      logic [2:0] cmd;
      logic [2:0] ba;
      logic [dmr_pkg::ADDR_W-1:0] addr;
      logic hot;
      logic [dmr_pkg::ADDR_W-1:0] wdata;
      logic [7:0] rd_byte;
      logic [dmr_pkg::CNT_W-1:0] cnt;
      logic [15:0] ref_count;
      logic [15:0] rdata;
   } dmr_cst_t;
   dmr_cst_t st_r;
   dmr_cst_t st_nxt;
   logic [dmr_pkg::CNT_W-1:0] limit;
   ////////////////////////////////////////////////////////////////////
   // ctrl bits: [0] write multipurpose, [1] write extended, [2] read, [3] hot
   always_comb begin
      st_nxt = st_r;
      st_nxt.cs_n = 1'b1;
      st_nxt.cmd = dmr_pkg::CMD_NOP;
      st_nxt.rdata = 16'h0000;
      if (link.dq_valid) begin
         st_nxt.rd_byte = link.dq;
      end
      // hot interval halves the pacing; otherwise 7.8 us
      limit = st_r.hot ? dmr_pkg::CNT_W'(dmr_pkg::REFI_HOT_CYC)
                       : dmr_pkg::CNT_W'(dmr_pkg::REFI_NORMAL_CYC);
      st_nxt.cnt = st_r.cnt + 16'h0001;
      if (st_r.cnt >= limit - 16'h0001) begin
         st_nxt.cnt = dmr_pkg::CNT_RST;
         st_nxt.cs_n = 1'b0;
         st_nxt.cmd = dmr_pkg::CMD_REF;
         st_nxt.ref_count = st_r.ref_count + 16'h0001;
      end else if (wr_in && addr_in == dmr_pkg::REG_CTRL) begin
         st_nxt.hot = wdata_in[3];
         if (wdata_in[0]) begin
            // mode write to bank three; reserved bits zero
            st_nxt.cs_n = 1'b0;
            st_nxt.cmd = dmr_pkg::CMD_MODE;
            st_nxt.ba = dmr_pkg::BA_MULTI;
            st_nxt.addr = {12'h000, st_r.wdata[2:0]};
         end else if (wdata_in[1]) begin
            st_nxt.cs_n = 1'b0;
            st_nxt.cmd = dmr_pkg::CMD_MODE;
            st_nxt.ba = dmr_pkg::BA_EXT;
            st_nxt.addr = st_r.wdata;
         end else if (wdata_in[2]) begin
            st_nxt.cs_n = 1'b0;
            st_nxt.cmd = dmr_pkg::CMD_READ;
            st_nxt.ba = 3'h0;
         end
      end
      if (wr_in && addr_in == dmr_pkg::REG_WDATA) begin
         st_nxt.wdata = wdata_in[dmr_pkg::ADDR_W-1:0];
      end
      if (rd_in) begin
         unique case (addr_in)
            dmr_pkg::REG_CTRL: st_nxt.rdata = {12'h000, st_r.hot, 3'h0};
            dmr_pkg::REG_WDATA: st_nxt.rdata = {1'b0, st_r.wdata};
            dmr_pkg::REG_RDATA: st_nxt.rdata = {8'h00, st_r.rd_byte};
            dmr_pkg::REG_RCOUNT: st_nxt.rdata = st_r.ref_count;
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
   end
   // state register
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= '0;
         st_r.cs_n <= 1'b1;
         st_r.cmd <= dmr_pkg::CMD_NOP;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign link.cs_n = st_r.cs_n;
   assign link.ras_n = st_r.cmd[2];
   assign link.cas_n = st_r.cmd[1];
   assign link.we_n = st_r.cmd[0];
   assign link.ba = st_r.ba;
   assign link.addr = st_r.addr;
   assign rdata_out = st_r.rdata;
endmodule
`default_nettype wire

// *** bench/dmr_asserts.sv ***
// checker: link rules between controller and dram ends
`default_nettype none
module dmr_asserts (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [dmr_pkg::ADDR_W-1:0] addr,
   input wire logic [dmr_pkg::DATA_W-1:0] dq,
   input wire logic dq_valid
);
   localparam logic [31:0] PATS = {dmr_pkg::PATTERN_3, dmr_pkg::PATTERN_2,
      dmr_pkg::PATTERN_1, dmr_pkg::PATTERN_0};
   logic [2:0] cmd;
   logic mp_r;
   logic [1:0] sel_r;
   logic [15:0] gap_r;
   assign cmd = cs_n ? dmr_pkg::CMD_NOP : {ras_n, cas_n, we_n};
   // pattern state and refresh spacing as seen on the wire
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mp_r <= 1'b0;
         sel_r <= 2'h0;
         gap_r <= 16'h0000;
      end else begin
         gap_r <= (cmd == dmr_pkg::CMD_REF) ? 16'h0001 : gap_r + 16'h0001;
         if (cmd == dmr_pkg::CMD_MODE && ba == dmr_pkg::BA_MULTI) begin
            mp_r <= addr[2];
            sel_r <= addr[2] ? addr[1:0] : sel_r;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_rd; cmd == dmr_pkg::CMD_READ; endsequence
   sequence s_ans; dq_valid; endsequence
   a_mode_bank: assert property (cmd == dmr_pkg::CMD_MODE |-> ba[2] == 1'b0)
      else $error("mode write bank");
   a_rsvd_zero: assert property (cmd == 3'h0 && ba == 3'h3 |-> addr[14:3] == 12'h000)
      else $error("reserved bits set");
   a_read_answer: assert property (s_rd |=> s_ans)
      else $error("read not answered");
   a_answer_cause: assert property (s_ans |-> $past(cmd) == dmr_pkg::CMD_READ)
      else $error("answer without read");
   a_pattern_data: assert property (dq_valid && $past(mp_r) |-> dq == PATS[$past(sel_r)*8 +: 8])
      else $error("wrong pattern");
   a_refresh_max: assert property (gap_r <= dmr_pkg::REFI_NORMAL_CYC + 1)
      else $error("refresh late");
   a_refresh_min: assert property (cmd == dmr_pkg::CMD_REF |-> gap_r >= dmr_pkg::REFI_HOT_CYC - 1)
      else $error("refresh early");
   a_addr_hold: assert property (cs_n |-> $stable(ba) && $stable(addr))
      else $error("address moved while idle");
   a_reset_idle: assert property ($past(!nrst_in) |-> cs_n)
      else $error("command right after reset");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// testbench: both ends joined, driven through the register port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in, nrst_in, wr_in, rd_in, self_ref_in, mp_en_out, srt_out;
   logic self_ref_tick_out, hot;
   logic [3:0] addr_in;
   logic [15:0] wdata_in, rdata_out;
   logic [7:0] array_data_in;
   int error_cnt = 0, samples_checked = 0, i, s;
   dmr_if link_if ();
   dmr_ctrl u_dmr_ctrl (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .link(link_if),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out));
   dmr_dram u_dmr_dram (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .link(link_if),
      .self_ref_in(self_ref_in), .array_data_in(array_data_in), .mp_en_out(mp_en_out),
      .srt_out(srt_out), .self_ref_tick_out(self_ref_tick_out));
   dmr_asserts u_dmr_asserts (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
      .ba(link_if.ba), .addr(link_if.addr), .dq(link_if.dq), .dq_valid(link_if.dq_valid));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one strobe cycle; read data settled on return
   task automatic strobe(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= w;
      rd_in <= !w;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      #1;
   endtask
   // retried, since a write landing on a due refresh is dropped
   task automatic op(input logic [2:0] b, input logic [2:0] c);
      for (int t = 0; t < 4; t++) begin
         strobe(1'b1, dmr_pkg::REG_CTRL, {12'h000, hot, b});
         if (!link_if.cs_n && {link_if.ras_n, link_if.cas_n, link_if.we_n} == c) return;
      end
      error_cnt++;
      wrap_up();
   endtask
   task automatic rd_byte(input logic [7:0] exp);
      op(3'h4, dmr_pkg::CMD_READ);
      @(posedge core_clk_in);
      strobe(1'b0, dmr_pkg::REG_RDATA, 16'h0000);
      chk(rdata_out, {8'h00, exp});
   endtask
   // cycles between two refresh commands (w=0) or self refresh ticks
   task automatic gap(input bit w, input int exp);
      int k, n;
      k = -1;
      n = 0;
      for (int j = 0; j < 800 && n == 0; j++) begin
         @(posedge core_clk_in);
         #1;
         if (k >= 0) k++;
         if (w ? self_ref_tick_out : !link_if.cs_n && {link_if.ras_n, link_if.cas_n,
            link_if.we_n} == dmr_pkg::CMD_REF) begin
            if (k > 0) n = k;
            k = 0;
         end
      end
      if (n == 0) error_cnt++;
      if (n == 0) wrap_up();
      chk(n[15:0], exp[15:0]);
   endtask
   function automatic logic [7:0] pat_of(input logic [1:0] sel);
      logic [31:0] p;
      p = {dmr_pkg::PATTERN_3, dmr_pkg::PATTERN_2, dmr_pkg::PATTERN_1, dmr_pkg::PATTERN_0};
      return p[sel*8 +: 8];
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end
   initial begin
      {nrst_in, wr_in, rd_in, hot, addr_in, wdata_in, array_data_in} = 32'h0;
      self_ref_in = 1'b1;
      void'($urandom(26252));
      repeat (10) @(posedge core_clk_in);
      chk({14'h0, mp_en_out, srt_out}, 16'h0);
      nrst_in <= 1'b1;
      for (i = 0; i < 8; i++) begin
         s = (i < 4) ? i : $urandom % 4;
         strobe(1'b1, dmr_pkg::REG_WDATA, {13'h0, 1'b1, s[1:0]});
         op(3'h1, dmr_pkg::CMD_MODE);
         @(posedge core_clk_in);
         #1;
         chk({15'h0, mp_en_out}, 16'h1);
         rd_byte(pat_of(s[1:0]));
      end
      // source off with random select, array served
      @(posedge core_clk_in);
      array_data_in <= 8'($urandom);
      strobe(1'b1, dmr_pkg::REG_WDATA, {14'h0, 2'($urandom)});
      op(3'h1, dmr_pkg::CMD_MODE);
      rd_byte(array_data_in);
      chk({15'h0, mp_en_out}, 16'h0);
      hot = 1'b1;
      op(3'h4, dmr_pkg::CMD_READ);
      strobe(1'b0, dmr_pkg::REG_CTRL, 16'h0000);
      chk(rdata_out & 16'h0008, 16'h0008);
      gap(1'b0, dmr_pkg::REFI_HOT_CYC);
      hot = 1'b0;
      op(3'h4, dmr_pkg::CMD_READ);
      gap(1'b0, dmr_pkg::REFI_NORMAL_CYC);
      // self refresh single rate, then doubled
      gap(1'b1, dmr_pkg::SELF_REF_CYC);
      strobe(1'b1, dmr_pkg::REG_WDATA, 16'h0080);
      op(3'h2, dmr_pkg::CMD_MODE);
      @(posedge core_clk_in);
      #1;
      chk({15'h0, srt_out}, 16'h1);
      gap(1'b1, dmr_pkg::SELF_REF_CYC / 2);
      strobe(1'b0, 4'hf, 16'h0000);
      chk(rdata_out, 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
